//--- sram_port_pkg.sv
// constants, field layouts and carriers for the burst-of-two sram port
// assumes a single 100 MHz clock and an ahb-lite register master
package sram_port_pkg;
   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int DATA_W = 36;
   localparam int LANES  = 4;
   localparam int LANE_W = 9;
   localparam int ADDR_W = 4;
   localparam int DEPTH  = 16;
   localparam int CODE_W = 6;
   localparam logic [CODE_W-1:0] CODE_RESET = 6'h20;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int CAL_PERIOD      = 1024;
   localparam int CAL_CNT_W       = 10;
   localparam int DLL_LOCK_CYCLES = 2048;
   localparam int DLL_CNT_W       = 11;
   localparam int DLL_STOP_NS     = 30;
   // longest run of quiet cycles still tolerated (rounded down)
   localparam int DLL_STOP_CYCLES = DLL_STOP_NS / CLK_PERIOD_NS;
   localparam int QUIET_W         = 3;
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   localparam logic [31:0] CTRL_OFF   = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFF = 32'h0000_0004;
   localparam int   CTRL_CAL_EN       = 0;
   localparam logic CTRL_CAL_EN_RESET = 1'b1;
   localparam int   STAT_DRV_LSB      = 0;
   localparam int   STAT_TRM_LSB      = 8;
   localparam int   STAT_LOCK         = 16;
   localparam int   STAT_TERM         = 17;
   localparam int   STAT_BUSY         = 18;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'b0;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      logic              read;
      logic [ADDR_W-1:0] addr;
   } cmd_t;
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  en_n;
   } beat_t;
   typedef struct packed {
      logic [CODE_W-1:0] code;
   } stepper_st_t;
   typedef struct packed {
      cmd_t                            c1;
      cmd_t                            c2;
      beat_t                           b1;
      logic [DEPTH-1:0][2*DATA_W-1:0]  mem;
      logic [DATA_W-1:0]               q_rise;
      logic [DATA_W-1:0]               q_fall;
      logic                            oe;
      logic                            term_rise;
      logic                            term_fall;
      logic                            in_term;
      logic [CAL_CNT_W-1:0]            cal_cnt;
      logic                            eval;
      logic                            cal_en;
      logic [DLL_CNT_W-1:0]            dll_cnt;
      logic                            locked;
      logic [QUIET_W-1:0]              quiet;
      logic                            a_wr;
      logic [31:0]                     rdata;
      logic                            ready;
      logic                            resp;
   } port_st_t;
endpackage

//--- impedance_stepper.sv
// one impedance code that moves by at most one step per evaluation
// assumes raise and lower come from a comparator against the reference pin
`timescale 1ns/100ps
`default_nettype none
module impedance_stepper #(
   parameter logic [sram_port_pkg::CODE_W-1:0] INIT = sram_port_pkg::CODE_RESET
) (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic                              ce,
   input  wire logic                              eval,
   input  wire logic                              raise,
   input  wire logic                              lower,
   output logic [sram_port_pkg::CODE_W-1:0]       code
);
   sram_port_pkg::stepper_st_t s;
   sram_port_pkg::stepper_st_t next_s;

   // ---------------------------------------------------------------
   // stepping
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      // R02: single step, saturating
      if (eval) begin
         if (raise && !lower && s.code != '1) begin
            next_s.code = s.code + 1'b1;
         end else if (lower && !raise && s.code != '0) begin
            next_s.code = s.code - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s      <= '0;
         s.code <= INIT;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign code = s.code;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk iff ce); endclocking
   default disable iff (!rst_n);

   property p_one_step;
      $changed(code) |-> $past(eval) &&
         (code == $past(code) + 1'b1 || code == $past(code) - 1'b1);
   endproperty
   a_one_step: assert property (p_one_step) else $error("code moved without eval or by more than one"); // R02
endmodule
`default_nettype wire

//--- sram_burst_port.sv
// device-side port of a common-io burst-of-two ddr sram with termination
// assumes pins synchronous to clk; each cycle carries a rise and a fall lane
// Behaviour
// R01: free-running counter triggers periodic impedance evaluation
// R02: each evaluation moves code one step
// R03: input termination follows termination_enable, default off
// R04: controller never floats byte enables, clocks
// R05: data termination on except around read drive
// R06: termination off half cycle around drive
// R07: controller drives data during writes, idles
// R08: controller releases data during reads
// R09: controller minimises unterminated undriven turnaround gaps
// R10: controller waits power-up clocks before commands
// R11: controller waits 2048 cycles after dll enable
// R12: dll resets on disable or stopped clock
// R13: power-up wait covers lock if enabled first
// R14: drivers off one cycle after nop/write
// R15: termination sets level during that off cycle
// R16: byte enables sampled with each write beat
// R17: beat-only enables write that beat only
// R18: all enables high aborts the write
// R19: deselect ignores read_not_write, drains bursts first
// R20: controller sends beats after command, rise then fall
// R21: read beats two edges after command
// R22: each enable gates one nine-bit lane
`timescale 1ns/100ps
`default_nettype none
module sram_burst_port (
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire logic                                ce,
   input  wire logic                                hsel,
   input  wire logic [31:0]                         haddr,
   input  wire logic [1:0]                          htrans,
   input  wire logic                                hwrite,
   input  wire logic [2:0]                          hsize,
   input  wire logic [31:0]                         hwdata,
   input  wire logic                                hready,
   output logic                                     hreadyout,
   output logic [31:0]                              hrdata,
   output logic                                     hresp,
   input  wire logic                                command_load_n,
   input  wire logic                                read_not_write,
   input  wire logic [sram_port_pkg::ADDR_W-1:0]    address,
   input  wire logic [sram_port_pkg::DATA_W-1:0]    dq_in_rise,
   input  wire logic [sram_port_pkg::DATA_W-1:0]    dq_in_fall,
   input  wire logic [sram_port_pkg::LANES-1:0]     byte_write_n,
   input  wire logic [sram_port_pkg::LANES-1:0]     byte_write_fall_n,
   input  wire logic                                termination_enable,
   input  wire logic                                dll_disable_n,
   input  wire logic                                k_running,
   input  wire logic                                drv_raise,
   input  wire logic                                drv_lower,
   input  wire logic                                trm_raise,
   input  wire logic                                trm_lower,
   output logic [sram_port_pkg::DATA_W-1:0]         dq_out_rise,
   output logic [sram_port_pkg::DATA_W-1:0]         dq_out_fall,
   output logic                                     dq_oe,
   output logic                                     dq_term_rise,
   output logic                                     dq_term_fall,
   output logic                                     input_term_on,
   output logic [sram_port_pkg::CODE_W-1:0]         drive_code,
   output logic [sram_port_pkg::CODE_W-1:0]         term_code,
   output logic                                     dll_locked
);
   localparam int DW = sram_port_pkg::DATA_W;
   localparam int LW = sram_port_pkg::LANE_W;

   sram_port_pkg::port_st_t s;
   sram_port_pkg::port_st_t next_s;

   // ---------------------------------------------------------------
   // impedance codes
   // ---------------------------------------------------------------
   // R02: termination shares the driver mechanism
   impedance_stepper #(.INIT(sram_port_pkg::CODE_RESET)) u_drv (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .eval  (s.eval),
      .raise (drv_raise),
      .lower (drv_lower),
      .code  (drive_code)
   );
   impedance_stepper #(.INIT(sram_port_pkg::CODE_RESET)) u_trm (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .eval  (s.eval),
      .raise (trm_raise),
      .lower (trm_lower),
      .code  (term_code)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      sram_port_pkg::cmd_t pin_cmd;
      logic [2*DW-1:0]     word;
      logic [DW-1:0]       lo;
      logic [DW-1:0]       hi;
      logic [31:0]         status;
      logic                take;
      logic                ctrl_now;
      pin_cmd  = '0;
      word     = s.mem[s.c2.addr];
      lo       = word[DW-1:0];
      hi       = word[2*DW-1:DW];
      status   = '0;
      take     = 1'b0;
      ctrl_now = 1'b0;
      next_s   = s;

      // R19: a high load pin masks the read/write pin
      pin_cmd.valid = ~command_load_n;
      pin_cmd.read  = ~command_load_n & read_not_write;
      pin_cmd.addr  = address;
      next_s.c1     = pin_cmd;
      next_s.c2     = s.c1;

      // R16: first beat with its enables one edge after the command
      if (s.c1.valid && !s.c1.read) begin
         next_s.b1 = {dq_in_rise, byte_write_n};
      end

      // R22: lane l is bits l*9 .. l*9+8
      for (int l = 0; l < sram_port_pkg::LANES; l++) begin
         // R17: each beat honours only its own enables
         if (!s.b1.en_n[l]) begin
            lo[l*LW +: LW] = s.b1.data[l*LW +: LW];
         end
         if (!byte_write_fall_n[l]) begin
            hi[l*LW +: LW] = dq_in_fall[l*LW +: LW];
         end
      end
      // R18: with every enable high the word is rewritten unchanged
      if (s.c2.valid && !s.c2.read) begin
         next_s.mem[s.c2.addr] = {hi, lo};
      end

      // R21: read data goes out two edges after its command
      // R14: nop and write leave the drivers off in that slot
      // R15: that slot's level is left to the termination
      next_s.oe = s.c2.read;
      if (s.c2.read) begin
         next_s.q_rise = word[DW-1:0];
         next_s.q_fall = word[2*DW-1:DW];
      end

      // R03: an undriven enable pin reads low, so termination stays off
      next_s.in_term = termination_enable;
      // R05: data termination only drops around our own drive
      // R06: fall half before the first drive cycle is released
      next_s.term_fall = termination_enable & ~next_s.oe & ~s.c1.read;
      // R06: rise half after the last drive cycle is still released
      next_s.term_rise = termination_enable & ~next_s.oe & ~s.oe;

      // R01: free-running evaluation timer
      next_s.eval = 1'b0;
      if (s.cal_cnt == sram_port_pkg::CAL_CNT_W'(sram_port_pkg::CAL_PERIOD - 1)) begin
         next_s.cal_cnt = '0;
         next_s.eval    = s.cal_en;
      end else begin
         next_s.cal_cnt = s.cal_cnt + 1'b1;
      end

      // a stopped clock is seen as k_running low; saturate the count
      if (k_running) begin
         next_s.quiet = '0;
      end else if (s.quiet != '1) begin
         next_s.quiet = s.quiet + 1'b1;
      end
      // R12: disable or long clock stop restarts the lock wait
      if (!dll_disable_n || s.quiet > sram_port_pkg::QUIET_W'(sram_port_pkg::DLL_STOP_CYCLES)) begin
         next_s.dll_cnt = '0;
         next_s.locked  = 1'b0;
      end else if (!s.locked) begin
         if (s.dll_cnt == sram_port_pkg::DLL_CNT_W'(sram_port_pkg::DLL_LOCK_CYCLES - 1)) begin
            next_s.locked = 1'b1;
         end else begin
            next_s.dll_cnt = s.dll_cnt + 1'b1;
         end
      end

      // ahb-lite slave, zero wait states, always okay
      take = hsel & hready & (htrans == sram_port_pkg::HTRANS_NONSEQ)
             & (hsize == sram_port_pkg::HSIZE_WORD);
      // forward a write still in its data phase to a read behind it
      ctrl_now = s.a_wr ? hwdata[sram_port_pkg::CTRL_CAL_EN] : s.cal_en;
      status[sram_port_pkg::STAT_DRV_LSB +: sram_port_pkg::CODE_W] = drive_code;
      status[sram_port_pkg::STAT_TRM_LSB +: sram_port_pkg::CODE_W] = term_code;
      status[sram_port_pkg::STAT_LOCK] = s.locked;
      status[sram_port_pkg::STAT_TERM] = s.in_term;
      status[sram_port_pkg::STAT_BUSY] = s.c1.valid | s.c2.valid | s.oe;
      next_s.a_wr = take & hwrite & (haddr[31:2] == sram_port_pkg::CTRL_OFF[31:2]);
      if (s.a_wr) begin
         next_s.cal_en = hwdata[sram_port_pkg::CTRL_CAL_EN];
      end
      if (take && !hwrite) begin
         next_s.rdata = '0;
         if (haddr[31:2] == sram_port_pkg::CTRL_OFF[31:2]) begin
            next_s.rdata[sram_port_pkg::CTRL_CAL_EN] = ctrl_now;
         end else if (haddr[31:2] == sram_port_pkg::STATUS_OFF[31:2]) begin
            next_s.rdata = status;
         end
      end
      next_s.ready = 1'b1;
      next_s.resp  = sram_port_pkg::HRESP_OKAY;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s        <= '0;
         s.cal_en <= sram_port_pkg::CTRL_CAL_EN_RESET;
         s.ready  <= 1'b1;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign hreadyout     = s.ready;
   assign hrdata        = s.rdata;
   assign hresp         = s.resp;
   assign dq_out_rise   = s.q_rise;
   assign dq_out_fall   = s.q_fall;
   assign dq_oe         = s.oe;
   assign dq_term_rise  = s.term_rise;
   assign dq_term_fall  = s.term_fall;
   assign input_term_on = s.in_term;
   assign dll_locked    = s.locked;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk iff ce); endclocking
   default disable iff (!rst_n);

   property p_read_lat;
      !command_load_n && read_not_write |-> ##3 dq_oe;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read data not driven on time"); // R21

   property p_nop_off;
      command_load_n |-> ##3 !dq_oe;
   endproperty
   a_nop_off: assert property (p_nop_off) else $error("drivers on after deselect"); // R19

   property p_write_off;
      !command_load_n && !read_not_write |-> ##3 !dq_oe;
   endproperty
   a_write_off: assert property (p_write_off) else $error("drivers on after write"); // R14

   property p_term_before;
      $rose(dq_oe) |-> !$past(dq_term_fall) && !dq_term_rise;
   endproperty
   a_term_before: assert property (p_term_before) else $error("termination on before drive"); // R06

   property p_term_after;
      $fell(dq_oe) |-> !dq_term_rise;
   endproperty
   a_term_after: assert property (p_term_after) else $error("termination back too early"); // R06

   property p_term_idle;
      $past(rst_n) && $past(termination_enable) && !dq_oe && !$past(dq_oe) |-> dq_term_rise;
   endproperty
   a_term_idle: assert property (p_term_idle) else $error("termination off while idle"); // R05

   property p_input_term;
      rst_n && termination_enable |=> input_term_on;
   endproperty
   a_input_term: assert property (p_input_term) else $error("input termination not on"); // R03

   property p_eval_period;
      s.eval |-> $past(s.cal_cnt) == sram_port_pkg::CAL_CNT_W'(sram_port_pkg::CAL_PERIOD - 1);
   endproperty
   a_eval_period: assert property (p_eval_period) else $error("evaluation off period"); // R01

   property p_abort;
      s.c2.valid && !s.c2.read && (&s.b1.en_n) && (&byte_write_fall_n)
         |=> s.mem[$past(s.c2.addr)] == $past(s.mem[s.c2.addr]);
   endproperty
   a_abort: assert property (p_abort) else $error("aborted write changed memory"); // R18

   property p_lane0;
      s.c2.valid && !s.c2.read && !s.b1.en_n[0]
         |=> s.mem[$past(s.c2.addr)][LW-1:0] == $past(s.b1.data[LW-1:0]);
   endproperty
   a_lane0: assert property (p_lane0) else $error("first beat lane 0 not stored"); // R16

   property p_dll_reset;
      !dll_disable_n |=> !dll_locked [*2];
   endproperty
   a_dll_reset: assert property (p_dll_reset) else $error("dll lock kept while disabled"); // R12

   property p_beat2_lane0;
      s.c2.valid && !s.c2.read && !byte_write_fall_n[0]
         |=> s.mem[$past(s.c2.addr)][DW +: LW] == $past(dq_in_fall[LW-1:0]);
   endproperty
   a_beat2_lane0: assert property (p_beat2_lane0) else $error("beat 2 lane 0 lost"); // R16

   property p_lane0_keep;
      s.c2.valid && !s.c2.read && s.b1.en_n[0]
         |=> s.mem[$past(s.c2.addr)][LW-1:0] == $past(s.mem[s.c2.addr][LW-1:0]);
   endproperty
   a_lane0_keep: assert property (p_lane0_keep) else $error("masked lane 0 overwritten"); // R17

   property p_read_data;
      s.c2.read
         |=> dq_out_rise == $past(s.mem[s.c2.addr][DW-1:0]);
   endproperty
   a_read_data: assert property (p_read_data) else $error("first read beat wrong"); // R21

   property p_drive_quiet;
      dq_oe |-> !dq_term_rise && !dq_term_fall;
   endproperty
   a_drive_quiet: assert property (p_drive_quiet) else $error("termination while driving"); // R06

   property p_eval_gate;
      s.eval |-> $past(s.cal_en);
   endproperty
   a_eval_gate: assert property (p_eval_gate) else $error("evaluation while disabled"); // R01

   property p_code_hold;
      !$past(s.eval)
         |-> $stable(drive_code) && $stable(term_code);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("code moved off evaluation"); // R01

   property p_lock_count;
      $rose(dll_locked)
         |-> $past(s.dll_cnt) == sram_port_pkg::DLL_CNT_W'(sram_port_pkg::DLL_LOCK_CYCLES - 1);
   endproperty
   a_lock_count: assert property (p_lock_count) else $error("lock before the full wait"); // R11

   c_read:  cover property (!command_load_n && read_not_write ##3 dq_oe);
   c_write: cover property (s.c2.valid && !s.c2.read && !(&s.b1.en_n));
   c_abort: cover property (s.c2.valid && !s.c2.read && (&s.b1.en_n) && (&byte_write_fall_n));
   c_lock:  cover property ($rose(dll_locked));
   c_fall:  cover property (s.c2.valid && !s.c2.read && (&s.b1.en_n) && !(&byte_write_fall_n));
endmodule
`default_nettype wire

//--- sram_ctrl_model.sv
// far-side controller model: commands and late write beats on the pins
// assumes go is raised right after a clk edge; beats follow by one and two edges
`timescale 1ns/100ps
`default_nettype none
module sram_ctrl_model (
   input  wire logic                             clk,
   input  wire logic                             go,
   input  wire logic                             rd,
   input  wire logic [sram_port_pkg::ADDR_W-1:0] a,
   input  wire sram_port_pkg::beat_t             b1,
   input  wire sram_port_pkg::beat_t             b2,
   output logic                                  command_load_n,
   output logic                                  read_not_write,
   output logic [sram_port_pkg::ADDR_W-1:0]      address,
   output var sram_port_pkg::beat_t              rise,
   output var sram_port_pkg::beat_t              fall
);
   logic                 wr1;
   logic                 wr2;
   sram_port_pkg::beat_t p1;
   sram_port_pkg::beat_t p2;
   sram_port_pkg::beat_t q2;
   initial begin
      command_load_n = 1'b1;
      read_not_write = 1'b0;
      address = '0;
      rise = '{data: '0, en_n: 4'hF};
      fall = '{data: '0, en_n: 4'hF};
      wr1 = 1'b0;
      wr2 = 1'b0;
      forever @(posedge clk) begin
         command_load_n <= !go;
         read_not_write <= rd;
         address <= a;
         wr1 <= go && !rd;
         p1 <= b1;
         p2 <= b2;
         wr2 <= wr1;
         q2 <= p2;
         // beat one after the command, beat two next; enables never float
         if (wr1)
            rise <= p1;
         else
            rise <= '{data: ~rise.data, en_n: 4'hF};
         // outside write beats the data lines show a changing pattern
         if (wr2)
            fall <= q2;
         else
            fall <= '{data: ~fall.data, en_n: 4'hF};
      end
   end
endmodule
`default_nettype wire

//--- burst2_sram_port_odt_bytewrite_tb_top.sv
// self-checking bench for the burst-of-two sram port
// assumes zero-wait ahb answers and the pin-side controller model
`timescale 1ns/100ps
`default_nettype none
module burst2_sram_port_odt_bytewrite_tb_top;
   // ------
   // signals
   // ------
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, go, rd;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic command_load_n, read_not_write, termination_enable, dll_disable_n, k_running;
   logic drv_raise, drv_lower, trm_raise, trm_lower, dq_oe, dq_term_rise, dq_term_fall;
   logic input_term_on, dll_locked;
   logic [3:0] a, address;
   logic [35:0] dq_out_rise, dq_out_fall;
   logic [5:0] drive_code, term_code;
   sram_port_pkg::beat_t b1, b2, pr, pf;
   logic [71:0] mem [16];
   logic [71:0] exp_q [$];
   int failures = 0;
   int comparisons = 0;
   int cyc = 0;
   sram_burst_port uut (.clk, .rst_n, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .command_load_n, .read_not_write, .address,
      .dq_in_rise(pr.data), .dq_in_fall(pf.data), .byte_write_n(pr.en_n), .byte_write_fall_n(pf.en_n),
      .termination_enable, .dll_disable_n, .k_running, .drv_raise, .drv_lower, .trm_raise, .trm_lower,
      .dq_out_rise, .dq_out_fall, .dq_oe, .dq_term_rise, .dq_term_fall, .input_term_on, .drive_code,
      .term_code, .dll_locked);
   sram_ctrl_model ctl (.clk, .go, .rd, .a, .b1, .b2, .command_load_n, .read_not_write, .address,
      .rise(pr), .fall(pf));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk or negedge rst_n) cyc <= rst_n ? cyc + 1 : 0;
   // ------
   // checks
   // ------
   task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic bail();
      failures++;
      tally_and_finish();
   endtask
   // every driven read slot must match the oldest queued read
   always @(posedge clk) if (rst_n && dq_oe === 1'b1) begin
      chk("term while driving", 2'b00, {dq_term_rise, dq_term_fall});
      if (exp_q.size() == 0)
         chk("unexpected drive", 1'b0, 1'b1);
      else
         chk("read beats", exp_q.pop_front(), {dq_out_fall, dq_out_rise});
   end
   // ------
   // drivers
   // ------
   task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= sram_port_pkg::HTRANS_NONSEQ;
      haddr <= ad;
      hwrite <= w;
      hsize <= sram_port_pkg::HSIZE_WORD;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
         bail();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 40);
      q = hrdata;
      chk("hresp", sram_port_pkg::HRESP_OKAY, hresp);
      if (n >= 40)
         bail();
   endtask
   task automatic cmd(input logic rn, input logic [3:0] ad, input logic [3:0] e1, input logic [3:0] e2);
      logic [95:0] d;
      d = {$urandom(), $urandom(), $urandom()};
      go <= 1'b1;
      rd <= rn;
      a <= ad;
      b1 <= '{data: d[35:0], en_n: e1};
      b2 <= '{data: d[71:36], en_n: e2};
      if (rn)
         exp_q.push_back(mem[ad]);
      else
         for (int l = 0; l < 4; l++) begin
            if (!e1[l]) mem[ad][9*l +: 9] = d[9*l +: 9];
            if (!e2[l]) mem[ad][36+9*l +: 9] = d[36+9*l +: 9];
         end
      @(posedge clk);
   endtask
   // deselect slots carry a random read_not_write, which must be ignored
   task automatic idle(input int n);
      go <= 1'b0;
      rd <= 1'($urandom());
      repeat (n) @(posedge clk);
   endtask
   task automatic walk(input logic [14:0] pat);
      cmd(1'b1, 4'h3, 4'hF, 4'hF);
      idle(1);
      for (int i = 4; i >= 0; i--) begin
         @(posedge clk);
         chk("drive and term walk", pat[3*i +: 3], {dq_oe, dq_term_rise, dq_term_fall});
      end
   endtask
   task automatic wait_lock();
      for (int n = 0; dll_locked !== 1'b1; n++) begin
         if (n > 2200)
            bail();
         @(posedge clk);
      end
   endtask
   task automatic upto(input int c);
      while (cyc < c) @(posedge clk);
   endtask
   // ------
   // sequence
   // ------
   initial begin
      void'($urandom(32'h548D25D7));
      rst_n = 1'b0;
      {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
      {go, rd, a} = '0;
      b1 = '1;
      b2 = '1;
      termination_enable = 1'b1;
      // disable pin high before clocks start, so the start-up wait covers locking
      dll_disable_n = 1'b1;
      k_running = 1'b1;
      {drv_raise, drv_lower, trm_raise, trm_lower} = 4'h9;
      foreach (mem[i]) mem[i] = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ahb(1'b0, sram_port_pkg::CTRL_OFF, 32'h0, r);
      chk("ctrl reset", 1'b1, r);
      // no pin command before the lock wait has run
      wait_lock();
      chk("lock cycle", 1'b1, cyc >= 2048 && cyc <= 2050);
      upto(2560);
      chk("drive code", 6'h22, drive_code);
      chk("term code", 6'h1E, term_code);
      ahb(1'b0, sram_port_pkg::STATUS_OFF, 32'h0, r);
      chk("status", 32'h0003_1E22, r);
      ahb(1'b0, 32'h0000_0010, 32'h0, r);
      chk("unmapped", 32'h0, r);
      ahb(1'b1, sram_port_pkg::CTRL_OFF, 32'h0, r);
      ahb(1'b0, sram_port_pkg::CTRL_OFF, 32'h0, r);
      chk("ctrl", 32'h0, r);
      for (int i = 0; i < 16; i++) cmd(1'b0, 4'(i), 4'h0, 4'h0);
      for (int i = 0; i < 16; i++) cmd(1'b0, 4'(i), 4'(i), 4'(~i));
      cmd(1'b0, 4'h5, 4'hF, 4'hF);
      idle(4);
      for (int i = 0; i < 16; i++) cmd(1'b1, 4'(i), 4'hF, 4'hF);
      idle(8);
      walk(15'b011_010_100_001_011);
      termination_enable <= 1'b0;
      idle(3);
      chk("input term", 1'b0, input_term_on);
      walk(15'b000_000_100_000_000);
      termination_enable <= 1'b1;
      chk("reads left", 0, exp_q.size());
      upto(3584);
      chk("drive hold", 6'h22, drive_code);
      ahb(1'b1, sram_port_pkg::CTRL_OFF, 32'h1, r);
      upto(4608);
      chk("drive again", 6'h23, drive_code);
      // lock lost on disable and waited for again, kept over a short clock stop, lost on a long one
      dll_disable_n <= 1'b0;
      idle(2);
      chk("lock drop", 1'b0, dll_locked);
      dll_disable_n <= 1'b1;
      idle(1);
      wait_lock();
      k_running <= 1'b0;
      idle(3);
      k_running <= 1'b1;
      idle(2);
      chk("short stop", 1'b1, dll_locked);
      k_running <= 1'b0;
      idle(6);
      chk("long stop", 1'b0, dll_locked);
      tally_and_finish();
   end
endmodule
`default_nettype wire
